// >>> verilog/asrx_defines.vh
// constants for the asynchronous serial receiver
`ifndef ASRX_DEFINES_VH
`define ASRX_DEFINES_VH
`define ASRX_ADDR_CTRL      12'h000
`define ASRX_ADDR_STATUS    12'h004
`define ASRX_ADDR_DATA      12'h008
`define ASRX_ADDR_BAUD      12'h00C
`define ASRX_CTRL_ENABLE    0
`define ASRX_CTRL_INVERT    1
`define ASRX_CTRL_NINE      2
`define ASRX_CTRL_WAKE      3
`define ASRX_CTRL_SLEEP     4
`define ASRX_CTRL_IDLEWS    5
`define ASRX_CTRL_ILT       6
`define ASRX_ST_FULL        0
`define ASRX_ST_OVERRUN     1
`define ASRX_ST_NOISE       2
`define ASRX_ST_FRAME       3
`define ASRX_ST_PARITY      4
`define ASRX_ST_IDLE        5
`define ASRX_ST_ACTIVE      6
`define ASRX_BAUD_RESET     16'h0004
`define ASRX_SLOTS          5'h10
`define ASRX_BITS_8         4'hA
`define ASRX_BITS_9         4'hB
`endif

// >>> verilog/asrx_receiver.v
// receive half of an asynchronous serial port with an apb register slave
`timescale 1ns/1ps
`include "asrx_defines.vh"

// Function
// - invert the serial input first when the polarity-invert control is one
// - assemble and deliver characters only while the receiver enable bit is set
// - frame is low start, eight or nine data bits lsb first, high stop
// - after the stop bit, move the character into a non-full buffer, set full
// - full flag still set: set overrun, drop new character, keep old one
// - sample at sixteen times baud, sixteen slots per bit
// - falling edge is a low sample after three high samples
// - start check at slots three, five, seven; accept if two are low
// - every data and stop bit decided by majority of slots eight, nine, ten
// - start bit counts as low whenever the start check passed
// - any sample disagreeing with its bit level sets noise at transfer
// - keep hunting falling edges and realign slot timing on one past slot ten of a data bit
// - framing error without break preloads edge history with three highs
// - while framing flag is set, shifting runs but no transfer happens
// - sleep suppresses full, overrun, noise and framing except for an address-mark character, and idle unless idle-while-sleeping set
// - idle wakeup clears sleep after ten or eleven idle bit times
// - idle that wakes the receiver sets no idle flag unless option set
// - idle-while-sleeping set: an idle sets the idle flag while sleeping too
// - idle count starts after start bit, or after stop bit when type is one
// - address-mark wakeup clears sleep when the character msb is high
// - address-mark wake happens with the stop-bit transfer; that character is received
// - full clears on a status read while set followed by a data read
// - error flags set together with full, never on overrun
// - once idle sets, it waits for a new received character before setting again
// - ninth data bit kept in its own bit left of the data byte
module asrx_receiver #(
   parameter BAUD_W = 16
) (
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_n_i,
   // apb slave
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [11:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output wire        pready_o,
   output reg  [31:0] prdata_o,
   output wire        pslverr_o,
   // serial line
   input  wire        rxd_i
);

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   reg  [6:0]        ctrl_r;
   reg  [BAUD_W-1:0] baud_r;
   reg               rx_full_flag;
   reg               overrun_r;
   reg               noise_flag;
   reg               framing_error_flag;
   reg               idle_r;
   reg  [7:0]        data_r;
   reg               rx_ninth_bit;
   reg               stat_armed_r;
   reg               idle_armed_r;

   wire acc      = psel_i & penable_i;
   wire wr       = acc & pwrite_i;
   wire rd       = acc & ~pwrite_i;
   wire sel_ctrl = (paddr_i == `ASRX_ADDR_CTRL);
   wire sel_stat = (paddr_i == `ASRX_ADDR_STATUS);
   wire sel_data = (paddr_i == `ASRX_ADDR_DATA);
   wire sel_baud = (paddr_i == `ASRX_ADDR_BAUD);
   wire mapped   = sel_ctrl | sel_stat | sel_data | sel_baud;

   // zero-wait slave: every access phase completes in one cycle
   assign pready_o  = 1'b1;
   assign pslverr_o = acc & ~mapped;

   wire en     = ctrl_r[`ASRX_CTRL_ENABLE];
   wire inv    = ctrl_r[`ASRX_CTRL_INVERT];
   wire nine   = ctrl_r[`ASRX_CTRL_NINE];
   wire wake   = ctrl_r[`ASRX_CTRL_WAKE];
   wire sleep  = ctrl_r[`ASRX_CTRL_SLEEP];
   wire idlews = ctrl_r[`ASRX_CTRL_IDLEWS];
   wire idle_count_type    = ctrl_r[`ASRX_CTRL_ILT];

   // ----------------------------------------------------------------
   // sixteen-times sample tick
   // ----------------------------------------------------------------
   // the divider reloads at zero, so a tick comes every baud_r + 1 clocks
   reg [BAUD_W-1:0] div_r;
   wire tick = (div_r == {BAUD_W{1'b0}});

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_r <= {BAUD_W{1'b0}};
      end else if (tick) begin
         div_r <= baud_r;
      end else begin
         div_r <= div_r - {{(BAUD_W-1){1'b0}}, 1'b1};
      end
   end

   // ----------------------------------------------------------------
   // sampling and frame assembly
   // ----------------------------------------------------------------
   localparam ST_HUNT  = 3'b001;
   localparam ST_START = 3'b010;
   localparam ST_BITS  = 3'b100;

   wire       rx_s = rxd_i ^ inv;
   reg  [2:0] state_r;
   // last three samples for the falling-edge search
   reg  [2:0] hist_r;
   reg  [4:0] slot_r;
   reg  [3:0] bitn_r;
   reg  [2:0] smp_r;
   reg  [1:0] strt_r;
   reg        noisy_r;
   reg        strt_hi_r;
   reg  [8:0] shift_r;
   reg  [3:0] idle_cnt_r;
   reg  [4:0] idle_slot_r;
   reg        idle_run_r;
   reg        done_r;
   reg        fe_new_r;
   reg        brk_new_r;

   wire [3:0] nbits  = nine ? `ASRX_BITS_9 : `ASRX_BITS_8;
   wire       fall   = (hist_r == 3'b111) & ~rx_s;
   wire [2:0] smp_n  = {smp_r[1:0], rx_s};
   wire       maj    = (smp_n[0] & smp_n[1]) | (smp_n[0] & smp_n[2]) | (smp_n[1] & smp_n[2]);
   wire       disag  = ~(smp_n == 3'b000 || smp_n == 3'b111);
   wire [3:0] last_b = nbits - 4'h1;

   // character frame in shift_r: data lsb first, bit 8 ninth
   wire [8:0] frame  = nine ? shift_r : {1'b0, shift_r[8:1]};
   // both modes leave the most significant data bit at the top of the shifter
   wire       msb    = shift_r[8];

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r   <= ST_HUNT;
         hist_r    <= 3'b000;
         slot_r    <= 5'h00;
         bitn_r    <= 4'h0;
         smp_r     <= 3'b000;
         strt_r    <= 2'b00;
         noisy_r   <= 1'b0;
         strt_hi_r <= 1'b0;
         shift_r   <= 9'h000;
         done_r    <= 1'b0;
         fe_new_r  <= 1'b0;
         brk_new_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (!en) begin
            // a disabled receiver forgets its edge history
            state_r <= ST_HUNT;
            hist_r  <= 3'b000;
         end else if (tick) begin
            hist_r <= {hist_r[1:0], rx_s};
            case (state_r)
               ST_HUNT: begin
                  if (fall) begin
                     state_r <= ST_START;
                     slot_r  <= 5'h02;
                     strt_r  <= 2'b00;
                     noisy_r <= 1'b0;
                     strt_hi_r <= 1'b0;
                     bitn_r  <= 4'h0;
                  end
               end
               ST_START: begin
                  slot_r <= slot_r + 5'h01;
                  if (slot_r == 5'h03 || slot_r == 5'h05 || slot_r == 5'h07) begin
                     if (!rx_s) begin
                        strt_r <= strt_r + 2'b01;
                     end else begin
                        // start-check samples that read high count as noise
                        strt_hi_r <= 1'b1;
                     end
                  end
                  if (slot_r == 5'h07) begin
                     if (strt_r + {1'b0, ~rx_s} >= 2'b10) begin
                        state_r <= ST_BITS;
                        noisy_r <= strt_hi_r | rx_s;
                     end else begin
                        state_r <= ST_HUNT;
                     end
                  end
               end
               ST_BITS: begin
                  slot_r <= (slot_r == `ASRX_SLOTS) ? 5'h01 : slot_r + 5'h01;
                  if (slot_r == `ASRX_SLOTS) begin
                     bitn_r <= bitn_r + 4'h1;
                  end
                  // realign on a data-bit falling edge
                  // only late in a bit, so a bit's own edge is not counted twice
                  if (fall && bitn_r != 4'h0 && slot_r > 5'h0A) begin
                     slot_r <= 5'h02;
                     bitn_r <= bitn_r + 4'h1;
                  end
                  if (slot_r >= 5'h08 && slot_r <= 5'h0A) begin
                     smp_r <= smp_n;
                  end
                  if (slot_r == 5'h0A) begin
                     if (disag) begin
                        noisy_r <= 1'b1;
                     end
                     if (bitn_r != 4'h0 && bitn_r != last_b) begin
                        shift_r <= {maj, shift_r[8:1]};
                     end
                     if (bitn_r == last_b) begin
                        state_r   <= ST_HUNT;
                        done_r    <= 1'b1;
                        fe_new_r  <= ~maj;
                        brk_new_r <= ~maj & (frame == 9'h000);
                        // a low line that continues looks like a fresh start at once
                        if (~maj && frame != 9'h000) begin
                           hist_r <= 3'b111;
                        end
                     end
                  end
               end
               default: begin
                  state_r <= ST_HUNT;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // idle line detection
   // ----------------------------------------------------------------
   // the count restarts on every low sample, so only an unbroken high stretch counts
   wire idle_bit_end = idle_run_r & tick & (idle_slot_r == `ASRX_SLOTS);
   wire idle_hit     = idle_bit_end & (idle_cnt_r == nbits - 4'h1);

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         idle_cnt_r  <= 4'h0;
         idle_slot_r <= 5'h01;
         idle_run_r  <= 1'b0;
      end else if (!en || (tick && !rx_s)) begin
         idle_cnt_r  <= 4'h0;
         idle_slot_r <= 5'h01;
         idle_run_r  <= 1'b0;
      end else if (tick) begin
         if (!idle_run_r) begin
            if ((!idle_count_type && state_r == ST_BITS && bitn_r != 4'h0) ||
                (state_r == ST_HUNT && !done_r)) begin
               idle_run_r <= 1'b1;
            end
         end else if (idle_slot_r == `ASRX_SLOTS) begin
            idle_slot_r <= 5'h01;
            if (idle_cnt_r != nbits - 4'h1) begin
               idle_cnt_r <= idle_cnt_r + 4'h1;
            end
         end else begin
            idle_slot_r <= idle_slot_r + 5'h01;
         end
      end
   end

   // keeps one idle stretch from raising the idle event twice
   reg idle_seen_r;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         idle_seen_r <= 1'b0;
      end else begin
         idle_seen_r <= idle_hit | (idle_seen_r & idle_run_r);
      end
   end
   wire idle_event = idle_hit & ~idle_seen_r;

   // ----------------------------------------------------------------
   // flags, buffer and registers
   // ----------------------------------------------------------------
   wire stat_read  = rd & sel_stat;
   wire data_read  = rd & sel_data;
   wire clr_seq    = data_read & stat_armed_r;
   wire addr_hit   = done_r & wake & msb;
   wire awake      = ~sleep | addr_hit;
   wire xfer_ok    = done_r & awake & ~framing_error_flag;
   wire store      = xfer_ok & (~rx_full_flag | clr_seq);
   wire ovr        = xfer_ok & rx_full_flag & ~clr_seq;
   wire idle_set   = idle_event & idle_armed_r & (~sleep | idlews);
   // sleep clears on an address mark, or on a full idle character when wake is clear
   wire sleep_clr  = addr_hit | (idle_event & ~wake);
   wire [6:0] ctrl_wr = pwdata_i[6:0];

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_r             <= 7'h00;
         baud_r             <= `ASRX_BAUD_RESET;
         rx_full_flag       <= 1'b0;
         overrun_r          <= 1'b0;
         noise_flag         <= 1'b0;
         framing_error_flag <= 1'b0;
         idle_r             <= 1'b0;
         data_r             <= 8'h00;
         rx_ninth_bit       <= 1'b0;
         stat_armed_r       <= 1'b0;
         idle_armed_r       <= 1'b1;
      end else begin
         if (wr && sel_ctrl) begin
            ctrl_r <= ctrl_wr;
         end else if (sleep_clr) begin
            ctrl_r[`ASRX_CTRL_SLEEP] <= 1'b0;
         end
         if (wr && sel_baud) begin
            baud_r <= pwdata_i[BAUD_W-1:0];
         end
         // a status read arms the clear only while full or idle is set
         if (stat_read) begin
            stat_armed_r <= rx_full_flag | idle_r;
         end else if (data_read) begin
            stat_armed_r <= 1'b0;
         end
         // a store and a clearing data read in one cycle: the store wins
         if (store) begin
            rx_full_flag       <= 1'b1;
            data_r             <= frame[7:0];
            rx_ninth_bit       <= frame[8];
            noise_flag         <= noisy_r;
            framing_error_flag <= fe_new_r;
            idle_armed_r       <= 1'b1;
         end else if (clr_seq) begin
            rx_full_flag       <= 1'b0;
            noise_flag         <= 1'b0;
            framing_error_flag <= 1'b0;
         end
         if (done_r && awake && framing_error_flag == 1'b0 && fe_new_r && !store) begin
            framing_error_flag <= framing_error_flag;
         end
         if (ovr) begin
            overrun_r <= 1'b1;
         end else if (clr_seq) begin
            overrun_r <= 1'b0;
         end
         if (idle_set) begin
            idle_r       <= 1'b1;
            idle_armed_r <= 1'b0;
         end else if (clr_seq && idle_r) begin
            idle_r <= 1'b0;
         end
      end
   end

   // read data is captured in the setup cycle and stands through the access phase
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         prdata_o <= 32'h0000_0000;
         if (sel_ctrl) begin
            prdata_o <= {25'h0, ctrl_r};
         end else if (sel_stat) begin
            prdata_o <= {25'h0, state_r != ST_HUNT, idle_r, 1'b0,
                         framing_error_flag, noise_flag, overrun_r, rx_full_flag};
         end else if (sel_data) begin
            prdata_o <= {23'h0, rx_ninth_bit, data_r};
         end else if (sel_baud) begin
            prdata_o <= {{(32-BAUD_W){1'b0}}, baud_r};
         end
      end
   end

endmodule

// >>> bench/asrx_receiver_checker.sv
// concurrent checks on the receiver's apb port
`timescale 1ns/1ps
`include "asrx_defines.vh"
module asrx_receiver_checker (
   // clock and reset
   input wire        clk_i,
   input wire        rst_n_i,
   // apb slave
   input wire        psel_i,
   input wire        penable_i,
   input wire        pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire        pready_o,
   input wire [31:0] prdata_o,
   input wire        pslverr_o,
   // serial line
   input wire        rxd_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // ---------------------------------------------
   // access decode
   // ---------------------------------------------
   wire acc   = psel_i && penable_i;
   wire rd    = acc && !pwrite_i;
   wire rd_st = rd && paddr_i == `ASRX_ADDR_STATUS;
   wire unmap = paddr_i > `ASRX_ADDR_BAUD;
   reg  en_seen_r;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         en_seen_r <= 1'b0;
      else if (acc && pwrite_i && paddr_i == `ASRX_ADDR_CTRL && pwdata_i[`ASRX_CTRL_ENABLE])
         en_seen_r <= 1'b1;
   end
   a_ready_const: assert property (pready_o)
      else $error("pready low");
   a_err_unmapped: assert property (acc && unmap |-> pslverr_o)
      else $error("no error on unmapped access");
   a_err_access: assert property (pslverr_o |-> acc && unmap)
      else $error("stray error response");
   a_unmapped_zero: assert property (rd && unmap |-> prdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_read_held: assert property (rd |=> $stable(prdata_o))
      else $error("read data not held");
   a_off_quiet: assert property (rd_st && !en_seen_r |-> !prdata_o[`ASRX_ST_FULL])
      else $error("character while disabled");
   a_overrun_full: assert property (rd_st && prdata_o[`ASRX_ST_OVERRUN] |-> prdata_o[`ASRX_ST_FULL])
      else $error("overrun without full");
   a_errs_full: assert property (rd_st && (prdata_o[`ASRX_ST_NOISE] || prdata_o[`ASRX_ST_FRAME])
      |-> prdata_o[`ASRX_ST_FULL])
      else $error("error flag without full");
   a_data_width: assert property (rd && paddr_i == `ASRX_ADDR_DATA |-> prdata_o[31:9] == 23'h0)
      else $error("data above ninth bit");
endmodule

// >>> bench/asrx_tx_model.sv
// remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module asrx_tx_model #(
   parameter BIT_CLKS = 80
) (
   // clock
   input  wire  clk_i,
   // serial line
   output logic rxd_o
);
   initial rxd_o = 1'b1;
   // ---------------------------------------------
   // frame driver: idle bit, start, data lsb first, stop
   // ---------------------------------------------
   task automatic level(input logic l);
      @(posedge clk_i);
      rxd_o <= l;
   endtask
   // glt flips one sample slot inside data bit zero
   task automatic send(input logic [8:0] d, input int n, input logic stp, input logic inv, input logic glt);
      logic b;
      for (int i = 0; i < n + 3; i++) begin
         b = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : (i == n + 2) ? stp : d[i-2];
         for (int c = 0; c < BIT_CLKS; c++) begin
            @(posedge clk_i);
            rxd_o <= b ^ inv ^ (glt && i == 2 && c >= 42 && c < 47);
         end
      end
      level(~inv);
   endtask
endmodule

// >>> bench/asrx_receiver_tb.sv
// self-checking testbench for the serial receiver
`timescale 1ns/1ps
`include "asrx_defines.vh"
module asrx_receiver_tb;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] v;
   logic        pready;
   logic        pslverr;
   logic        rxd;
   logic        e;
   int          mismatches = 0;
   int          checked = 0;
   always #50 clk_i = ~clk_i;
   asrx_receiver dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .rxd_i(rxd));
   asrx_tx_model tx (.clk_i(clk_i), .rxd_o(rxd));
   // ---------------------------------------------
   // bus, compare and wait helpers
   // ---------------------------------------------
   task automatic wrap_up;
      $display("mismatches=%0d checked=%0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         mismatches++;
         wrap_up();
      end
      v = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
      @(posedge clk_i);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      checked++;
      if (g !== x) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, g, x);
      end
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
      apb(a, 1'b0, 32'h0);
      chk(v & m, x);
   endtask
   task automatic bits(input int k);
      repeat (k * 80) @(posedge clk_i);
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic s_reset;
      rdc(`ASRX_ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
      rdc(`ASRX_ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
      rdc(`ASRX_ADDR_BAUD, 32'hFFFFFFFF, {16'h0000, `ASRX_BAUD_RESET});
      rdc(12'h010, 32'hFFFFFFFF, 32'h0);
      chk({31'h0, e}, 32'h1);
   endtask
   task automatic s_basic;
      tx.send(9'h0A5, 8, 1'b1, 1'b0, 1'b0);
      rdc(`ASRX_ADDR_STATUS, 32'h1F, 32'h0);
      apb(`ASRX_ADDR_CTRL, 1'b1, 32'h1);
      tx.send(9'h0A5, 8, 1'b1, 1'b0, 1'b0);
      rdc(`ASRX_ADDR_STATUS, 32'h1F, 32'h01);
      rdc(`ASRX_ADDR_DATA, 32'h1FF, 32'h0A5);
      rdc(`ASRX_ADDR_STATUS, 32'h1F, 32'h0);
   endtask
   task automatic s_errors;
      tx.send(9'h03C, 8, 1'b1, 1'b0, 1'b0);
      tx.send(9'h0C3, 8, 1'b1, 1'b0, 1'b0);
      rdc(`ASRX_ADDR_STATUS, 32'h1F, 32'h03);
      rdc(`ASRX_ADDR_DATA, 32'h1FF, 32'h03C);
      tx.send(9'h05A, 8, 1'b1, 1'b0, 1'b1);
      rdc(`ASRX_ADDR_STATUS, 32'h1F, 32'h05);
      rdc(`ASRX_ADDR_DATA, 32'h1FF, 32'h05A);
      tx.send(9'h055, 8, 1'b0, 1'b0, 1'b0);
      bits(12);
      rdc(`ASRX_ADDR_STATUS, 32'h1F, 32'h09);
      rdc(`ASRX_ADDR_DATA, 32'h1FF, 32'h055);
      tx.send(9'h000, 8, 1'b0, 1'b0, 1'b0);
      rdc(`ASRX_ADDR_STATUS, 32'h1F, 32'h09);
      rdc(`ASRX_ADDR_DATA, 32'h1FF, 32'h000);
      tx.send(9'h081, 8, 1'b1, 1'b0, 1'b0);
      rdc(`ASRX_ADDR_STATUS, 32'h1F, 32'h01);
      rdc(`ASRX_ADDR_DATA, 32'h1FF, 32'h081);
   endtask
   task automatic s_wake;
      apb(`ASRX_ADDR_CTRL, 1'b1, 32'h19);
      tx.send(9'h012, 8, 1'b1, 1'b0, 1'b0);
      rdc(`ASRX_ADDR_STATUS, 32'h3F, 32'h0);
      tx.send(9'h092, 8, 1'b1, 1'b0, 1'b0);
      rdc(`ASRX_ADDR_CTRL, 32'h7F, 32'h09);
      rdc(`ASRX_ADDR_STATUS, 32'h1F, 32'h01);
      rdc(`ASRX_ADDR_DATA, 32'h1FF, 32'h092);
      apb(`ASRX_ADDR_CTRL, 1'b1, 32'h11);
      tx.send(9'h012, 8, 1'b1, 1'b0, 1'b0);
      bits(12);
      rdc(`ASRX_ADDR_CTRL, 32'h7F, 32'h01);
      rdc(`ASRX_ADDR_STATUS, 32'h3F, 32'h0);
      tx.send(9'h034, 8, 1'b1, 1'b0, 1'b0);
      bits(12);
      rdc(`ASRX_ADDR_STATUS, 32'h3F, 32'h21);
      rdc(`ASRX_ADDR_DATA, 32'h1FF, 32'h034);
      bits(12);
      rdc(`ASRX_ADDR_STATUS, 32'h3F, 32'h0);
   endtask
   task automatic s_nine_inv;
      apb(`ASRX_ADDR_CTRL, 1'b1, 32'h06);
      tx.level(1'b0);
      apb(`ASRX_ADDR_CTRL, 1'b1, 32'h07);
      tx.send(9'h1A3, 9, 1'b1, 1'b1, 1'b0);
      rdc(`ASRX_ADDR_STATUS, 32'h1F, 32'h01);
      rdc(`ASRX_ADDR_DATA, 32'h1FF, 32'h1A3);
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      s_reset();
      s_basic();
      s_errors();
      s_wake();
      s_nine_inv();
      wrap_up();
   end
endmodule
bind asrx_receiver asrx_receiver_checker chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
   .prdata_o(prdata_o), .pslverr_o(pslverr_o), .rxd_i(rxd_i));
